// *** hw/qrs_pkg.sv ***
// Constants shared by the quasi-resonant switch timing logic.
// Assumes a 40 MHz core clock and comparator levels from the analog front end.
// Function
// RQ1 - Judge feedback against zone thresholds each 48ms period; update skip count at its end.
// RQ2 - Feedback always below low zone: skip count goes up, saturating at 7.
// RQ3 - Feedback above low zone but never above high zone: skip count unchanged.
// RQ4 - Feedback above high zone, never above reset level: skip count down, stopping at 1.
// RQ5 - Feedback above reset threshold at any time loads skip count with 1.
// RQ6 - Skip count stays in 1 to 7; steps leaving that range are ignored.
// RQ7 - Skip count starts at 1 after start-up.
// RQ8 - Zone threshold set is chosen by line-voltage level, independent of foldback.
// RQ9 - Valley count stays within 0 to 7.
// RQ10 - After switch-off each valley pin fall below 100mV adds one to valley count.
// RQ11 - Valley count clears whenever the gate drive goes high.
// RQ12 - Valley pin above overvoltage level while off latches off after blanking.
// RQ13 - Ringing suppression starts at switch-off; long below select level, short above.
// RQ14 - Gate stays low throughout ringing suppression.
// RQ15 - After suppression, gate turns on once valley count reaches skip count.
// RQ16 - Gate turns on after maximum off time whatever the counts.
// RQ17 - Gate turns off when scaled sense exceeds the regulation input.
// RQ18 - Off comparators ignored for leading edge blank time after turn-on.
// RQ19 - Gate forced off after maximum on time.
// RQ20 - Current-limit comparator after blanking turns gate off at once.
// RQ21 - Short-winding comparator must hold for its blank time before latch-off.
// RQ22 - Sense limit is reduced digitally by foldback current excess.
// RQ23 - Each period latches whether each feedback comparator fired; cleared next period.

package qrs_pkg;

	// ----------------------------------------------------------------
	// Clock and times
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS       = 25;
	localparam int EVAL_PERIOD_MS      = 48;
	localparam int EVAL_PERIOD_CYC     = EVAL_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int MAX_OFF_TIME_NS     = 50000;
	localparam int MAX_OFF_CYC         = MAX_OFF_TIME_NS / CLK_PERIOD_NS;
	localparam int MAX_ON_TIME_NS      = 30000;
	localparam int MAX_ON_CYC          = MAX_ON_TIME_NS / CLK_PERIOD_NS;
	localparam int LEB_TIME_NS         = 220;
	localparam int LEB_CYC             = (LEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RING_LONG_NS        = 25000;
	localparam int RING_LONG_CYC       = (RING_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RING_SHORT_NS       = 2500;
	localparam int RING_SHORT_CYC      = (RING_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OVP_BLANK_NS        = 1000;
	localparam int OVP_BLANK_CYC       = (OVP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SHORT_BLANK_NS      = 190;
	localparam int SHORT_BLANK_CYC     = (SHORT_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Counters and limit codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SKIP_MIN    = 3'h1;
	localparam logic [2:0] SKIP_MAX    = 3'h7;
	localparam logic [2:0] SKIP_RESET  = 3'h1;
	localparam logic [2:0] VALLEY_MAX  = 3'h7;
	localparam int         LIMIT_W     = 6;
	localparam logic [5:0] LIMIT_MAX   = 6'h3F;
	localparam logic [5:0] LIMIT_FLOOR = 6'h10;

endpackage

// *** hw/qrs_sync.sv ***
// Three-stage synchroniser for comparator levels arriving from the pins.
// Assumes inputs are asynchronous levels; output follows once stages two and three agree.
`timescale 1ns/10ps

module qrs_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_level
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} qrs_sync_t;

	qrs_sync_t s;
	qrs_sync_t next_s;

	// ----------------------------------------------------------------
	// Agreement filter
	// ----------------------------------------------------------------
	// Stage one feeds stage two only; a single-cycle glitch never reaches q
	always_comb begin
		next_s    = s;
		next_s.s1 = i_async;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		for (int b = 0; b < WIDTH; b++) begin
			if (s.s2[b] == s.s3[b]) begin
				next_s.q[b] = s.s3[b];
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_level = s.q;

endmodule

// *** hw/qrs_switch_timing.sv ***
// Switch-timing core of a quasi-resonant flyback controller.
// Assumes all i_ comparator levels come straight from analog pins (asynchronous).
`timescale 1ns/10ps

module qrs_switch_timing #(
	parameter int EVAL_CYC = qrs_pkg::EVAL_PERIOD_CYC,
	parameter int FOLD_W   = 6
) (
	input  wire logic              i_core_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_fb_above_zone_low,
	input  wire logic              i_fb_above_zone_high,
	input  wire logic              i_fb_above_reset,
	input  wire logic              i_line_high,
	input  wire logic              i_valley_below_zc,
	input  wire logic              i_valley_above_ovp,
	input  wire logic              i_valley_above_suppress,
	input  wire logic              i_cs_above_fb,
	input  wire logic              i_cs_above_limit,
	input  wire logic              i_cs_above_short,
	input  wire logic [FOLD_W-1:0] i_foldback_excess,
	output logic                   o_gate_drive_output,
	output logic                   o_latched_off,
	output logic                   o_zone_set_high,
	output logic      [2:0]        o_valley_skip,
	output logic      [2:0]        o_valley_count,
	output logic      [5:0]        o_cs_limit_code
);

	localparam int PW = $clog2(EVAL_CYC + 1);
	localparam int SW = 10 + FOLD_W;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_OFF,
		ST_ON,
		ST_LATCHED
	} qrs_state_t;

	typedef struct packed {
		qrs_state_t    state;
		logic          gate;
		logic [2:0]    skip;
		logic [2:0]    valley;
		logic          seen_low;
		logic          seen_high;
		logic          seen_reset;
		logic [PW-1:0] period;
		logic [15:0]   timer;
		logic [15:0]   ring;
		logic [15:0]   ovp;
		logic [15:0]   short_cnt;
		logic          valley_prev;
		logic          zone_high;
		logic [5:0]    limit;
		logic          latched;
	} qrs_core_t;

	qrs_core_t s;
	qrs_core_t next_s;

	logic [SW-1:0]     sync_q;
	logic              fb_low;
	logic              fb_high;
	logic              fb_rst;
	logic              line_hi;
	logic              zc_below;
	logic              zc_ovp;
	logic              zc_supp;
	logic              cs_fb;
	logic              cs_lim;
	logic              cs_short;
	logic [FOLD_W-1:0] fold;
	logic              valley_edge;
	logic              blanked;

	qrs_sync #(
		.WIDTH(SW)
	) u_sync (
		.i_core_clk(i_core_clk),
		.i_rst_n   (i_rst_n),
		.i_async   ({i_foldback_excess, i_cs_above_short, i_cs_above_limit,
		              i_cs_above_fb, i_valley_above_suppress, i_valley_above_ovp,
		              i_valley_below_zc, i_line_high, i_fb_above_reset,
		              i_fb_above_zone_high, i_fb_above_zone_low}),
		.o_level   (sync_q)
	);

	assign fb_low   = sync_q[0];
	assign fb_high  = sync_q[1];
	assign fb_rst   = sync_q[2];
	assign line_hi  = sync_q[3];
	assign zc_below = sync_q[4];
	assign zc_ovp   = sync_q[5];
	assign zc_supp  = sync_q[6];
	assign cs_fb    = sync_q[7];
	assign cs_lim   = sync_q[8];
	assign cs_short = sync_q[9];
	assign fold     = sync_q[SW-1:10];

	assign valley_edge = zc_below && !s.valley_prev;
	assign blanked     = s.timer < 16'(qrs_pkg::LEB_CYC);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		next_s             = s;
		next_s.valley_prev = zc_below;
		// Comparator levels are already filtered, so no extra hysteresis here
		next_s.zone_high   = line_hi; // [RQ8]

		// Saturating subtract keeps a floor so the switch can always deliver power
		if ({{(6 > FOLD_W ? 6 - FOLD_W : 0){1'b0}}, fold} >=
		    7'(qrs_pkg::LIMIT_MAX - qrs_pkg::LIMIT_FLOOR)) begin
			next_s.limit = qrs_pkg::LIMIT_FLOOR; // [RQ22]
		end else begin
			next_s.limit = qrs_pkg::LIMIT_MAX - 6'(fold); // [RQ22]
		end

		// Period flags; at period end the new period starts from the live level
		if (s.period == PW'(EVAL_CYC - 1)) begin
			next_s.period     = '0;
			next_s.seen_low   = fb_low; // [RQ23]
			next_s.seen_high  = fb_high; // [RQ23]
			next_s.seen_reset = fb_rst; // [RQ23]
			if (!s.seen_low) begin
				if (s.skip != qrs_pkg::SKIP_MAX) begin
					next_s.skip = s.skip + 3'h1; // [RQ2] [RQ6]
				end
			end else if (!s.seen_high) begin
				next_s.skip = s.skip; // [RQ3]
			end else if (!s.seen_reset) begin
				if (s.skip != qrs_pkg::SKIP_MIN) begin
					next_s.skip = s.skip - 3'h1; // [RQ4] [RQ6]
				end
			end else begin
				next_s.skip = qrs_pkg::SKIP_RESET; // [RQ1]
			end
		end else begin
			next_s.period     = s.period + PW'(1);
			next_s.seen_low   = s.seen_low | fb_low; // [RQ23]
			next_s.seen_high  = s.seen_high | fb_high; // [RQ23]
			next_s.seen_reset = s.seen_reset | fb_rst; // [RQ23]
		end
		// Immediate reload lets the loop react to a load step within the period
		if (fb_rst) begin
			next_s.skip = qrs_pkg::SKIP_RESET; // [RQ5]
		end

		case (s.state)
			ST_OFF: begin
				next_s.timer = s.timer + 16'h0001;
				if (s.ring != 16'h0000) begin
					next_s.ring = s.ring - 16'h0001;
				end
				if (valley_edge && s.valley != qrs_pkg::VALLEY_MAX) begin
					next_s.valley = s.valley + 3'h1; // [RQ9] [RQ10]
				end
				if (zc_ovp) begin
					next_s.ovp = s.ovp + 16'h0001;
				end else begin
					next_s.ovp = '0;
				end
				if (zc_ovp && s.ovp == 16'(qrs_pkg::OVP_BLANK_CYC - 1)) begin
					next_s.state = ST_LATCHED; // [RQ12]
				end else if (s.timer >= 16'(qrs_pkg::MAX_OFF_CYC - 1)) begin
					next_s.state = ST_ON; // [RQ16]
				end else if (s.ring == 16'h0000 && s.valley >= s.skip) begin
					next_s.state = ST_ON; // [RQ14] [RQ15]
				end
				if (next_s.state == ST_ON) begin
					next_s.gate   = 1'b1;
					next_s.valley = '0; // [RQ11]
					next_s.timer  = '0;
					next_s.ovp    = '0;
				end
			end
			ST_ON: begin
				next_s.timer = s.timer + 16'h0001;
				if (cs_short) begin
					next_s.short_cnt = s.short_cnt + 16'h0001;
				end else begin
					next_s.short_cnt = '0;
				end
				if (cs_short && s.short_cnt == 16'(qrs_pkg::SHORT_BLANK_CYC - 1)) begin
					next_s.state = ST_LATCHED; // [RQ21]
				end else if (s.timer >= 16'(qrs_pkg::MAX_ON_CYC - 1)) begin
					next_s.state = ST_OFF; // [RQ19]
				end else if (!blanked && (cs_fb || cs_lim)) begin
					next_s.state = ST_OFF; // [RQ17] [RQ18] [RQ20]
				end
				if (next_s.state == ST_OFF) begin
					next_s.gate      = 1'b0;
					next_s.timer     = '0;
					next_s.short_cnt = '0;
					// Low ringing level means a weak output: wait longer
					next_s.ring      = zc_supp ? 16'(qrs_pkg::RING_SHORT_CYC)
					                           : 16'(qrs_pkg::RING_LONG_CYC); // [RQ13]
				end
			end
			ST_LATCHED: begin
				// Only a reset leaves this state
				next_s.gate  = 1'b0;
				next_s.timer = '0;
			end
			default: begin
				next_s.state = ST_LATCHED;
				next_s.gate  = 1'b0;
			end
		endcase
		if (next_s.state == ST_LATCHED) begin
			next_s.gate = 1'b0;
		end
		// Registered copy so the protection output comes straight from a flop
		next_s.latched = next_s.state == ST_LATCHED;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s       <= '0;
			s.skip  <= qrs_pkg::SKIP_RESET; // [RQ7]
			s.limit <= qrs_pkg::LIMIT_MAX;
		end else begin
			s <= next_s;
		end
	end

	assign o_gate_drive_output = s.gate;
	assign o_latched_off       = s.latched;
	assign o_zone_set_high     = s.zone_high;
	assign o_valley_skip       = s.skip;
	assign o_valley_count      = s.valley;
	assign o_cs_limit_code     = s.limit;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_skip_range: assert property (s.skip >= 3'h1 && s.skip <= 3'h7) // [RQ6]
		else $error("skip count out of range");
	a_skip_reload: assert property (fb_rst |=> s.skip == 3'h1) // [RQ5]
		else $error("skip count not reloaded");
	a_skip_up: assert property (s.period == PW'(EVAL_CYC - 1) && !s.seen_low && !fb_rst // [RQ2]
		|=> s.skip == ($past(s.skip) == 3'h7 ? 3'h7 : $past(s.skip) + 3'h1))
		else $error("skip count did not step up");
	a_valley_step: assert property (s.state == ST_OFF && valley_edge && s.valley < 3'h7 // [RQ10]
		&& next_s.state == ST_OFF |=> s.valley == $past(s.valley) + 3'h1)
		else $error("valley count did not step");
	a_valley_clear: assert property ($rose(s.gate) |-> s.valley == 3'h0) // [RQ11]
		else $error("valley count not cleared at turn-on");
	a_ring_hold: assert property ($fell(s.gate) |-> !s.gate [*8]) // [RQ14]
		else $error("gate rose during ringing suppression");
	a_blank_min: assert property ($rose(s.gate) |-> s.gate [*8]) // [RQ18]
		else $error("gate shorter than blanking time");
	a_on_limit: assert property (s.gate |-> s.timer < 16'(qrs_pkg::MAX_ON_CYC)) // [RQ19]
		else $error("gate exceeded maximum on time");
	a_cs_off: assert property (s.state == ST_ON && !blanked && (cs_fb || cs_lim) // [RQ17]
		|=> !s.gate)
		else $error("sense comparator did not turn gate off");
	a_off_limit: assert property (s.state == ST_OFF && s.timer == 16'(qrs_pkg::MAX_OFF_CYC - 1) // [RQ16]
		&& !(zc_ovp && s.ovp == 16'(qrs_pkg::OVP_BLANK_CYC - 1)) |=> s.gate)
		else $error("maximum off time did not turn gate on");
	a_latch_stays: assert property (o_latched_off |=> o_latched_off && !s.gate) // [RQ12]
		else $error("latched-off state left without reset");

	c_turn_on: cover property ($rose(s.gate));
	c_latched: cover property ($rose(o_latched_off));
	c_skip_max: cover property (s.skip == 3'h7);
	c_valley_on: cover property (s.valley >= 3'h3 ##1 $rose(s.gate));
	c_skip_drop: cover property (s.skip == 3'h2 ##1 s.skip == 3'h1);

	// ----------------------------------------------------------------
	// Valley-skip counter and period flags
	// ----------------------------------------------------------------
	// The skip count may only move at a period end or on a reset-level reload
	a_skip_down: assert property (s.period == PW'(EVAL_CYC - 1) && s.seen_low && s.seen_high // [RQ4]
		&& !s.seen_reset && !fb_rst
		|=> s.skip == ($past(s.skip) == 3'h1 ? 3'h1 : $past(s.skip) - 3'h1))
		else $error("skip count did not step down");
	a_skip_hold: assert property (s.period == PW'(EVAL_CYC - 1) && s.seen_low && !s.seen_high // [RQ3]
		&& !fb_rst |=> $stable(s.skip))
		else $error("skip count changed in hold zone");
	a_skip_mid: assert property (s.period != PW'(EVAL_CYC - 1) && !fb_rst // [RQ1]
		|=> $stable(s.skip))
		else $error("skip count changed inside a period");
	a_skip_set: assert property (s.period == PW'(EVAL_CYC - 1) && s.seen_reset // [RQ5]
		|=> s.skip == 3'h1)
		else $error("skip count not set at period end");
	a_period_wrap: assert property (s.period == PW'(EVAL_CYC - 1) // [RQ1]
		|=> s.period == PW'(0))
		else $error("period counter did not wrap");
	a_flags_restart: assert property (s.period == PW'(EVAL_CYC - 1) // [RQ23]
		|=> s.seen_low == $past(fb_low) && s.seen_high == $past(fb_high))
		else $error("period flags not restarted");
	a_flags_stick: assert property (s.seen_low && s.period != PW'(EVAL_CYC - 1) // [RQ23]
		|=> s.seen_low)
		else $error("period flag lost inside a period");

	// ----------------------------------------------------------------
	// Valley counter and switch-on
	// ----------------------------------------------------------------
	// Ringing edges are counted but must never start a pulse early
	a_valley_sat: assert property (s.state == ST_OFF && s.valley == 3'h7 // [RQ9]
		&& next_s.state == ST_OFF |=> s.valley == 3'h7)
		else $error("valley count left its range");
	a_valley_hold: assert property (s.state == ST_OFF && !valley_edge // [RQ10]
		&& next_s.state == ST_OFF |=> $stable(s.valley))
		else $error("valley count moved without an edge");
	a_valley_on: assert property (s.state == ST_ON |-> s.valley == 3'h0) // [RQ11]
		else $error("valley count not zero while on");
	a_ring_load: assert property (s.state == ST_ON && next_s.state == ST_OFF // [RQ13]
		|=> s.ring == ($past(zc_supp) ? 16'(qrs_pkg::RING_SHORT_CYC)
		                             : 16'(qrs_pkg::RING_LONG_CYC)))
		else $error("suppression time loaded wrongly");
	a_ring_gate: assert property (s.state == ST_OFF && s.ring != 16'h0000 // [RQ14]
		&& s.timer < 16'(qrs_pkg::MAX_OFF_CYC - 1) |=> !s.gate)
		else $error("gate rose inside suppression time");
	a_valley_gate: assert property (s.state == ST_OFF && s.ring == 16'h0000 && s.valley >= s.skip // [RQ15]
		&& !(zc_ovp && s.ovp == 16'(qrs_pkg::OVP_BLANK_CYC - 1)) |=> s.gate)
		else $error("enough valleys did not turn gate on");
	a_off_max: assert property (s.state == ST_OFF |-> s.timer < 16'(qrs_pkg::MAX_OFF_CYC)) // [RQ16]
		else $error("off time exceeded its maximum");

	// ----------------------------------------------------------------
	// Switch-off, protection and limits
	// ----------------------------------------------------------------
	// Only the short-winding filter may end a pulse inside the blank time
	a_blank_hold: assert property (s.state == ST_ON && blanked // [RQ18]
		&& !(cs_short && s.short_cnt == 16'(qrs_pkg::SHORT_BLANK_CYC - 1)) |=> s.gate)
		else $error("gate fell inside blanking time");
	a_limit_off: assert property (s.state == ST_ON && !blanked && cs_lim // [RQ20]
		|=> !s.gate)
		else $error("current limit did not turn gate off");
	a_ovp_latch: assert property (s.state == ST_OFF && zc_ovp // [RQ12]
		&& s.ovp == 16'(qrs_pkg::OVP_BLANK_CYC - 1) |=> o_latched_off)
		else $error("overvoltage did not latch off");
	a_short_latch: assert property (s.state == ST_ON && cs_short // [RQ21]
		&& s.short_cnt == 16'(qrs_pkg::SHORT_BLANK_CYC - 1) |=> o_latched_off)
		else $error("short winding did not latch off");
	a_short_spike: assert property (s.state == ST_ON && !cs_short // [RQ21]
		|=> !o_latched_off)
		else $error("latched off without short winding");
	a_latch_gate: assert property (o_latched_off |-> !o_gate_drive_output) // [RQ12]
		else $error("gate high while latched off");
	a_zone_select: assert property (1'b1 |=> o_zone_set_high == $past(line_hi)) // [RQ8]
		else $error("zone set does not follow line level");
	a_limit_code: assert property (1'b1 |=> o_cs_limit_code == // [RQ22]
		($past(fold) >= qrs_pkg::LIMIT_MAX - qrs_pkg::LIMIT_FLOOR ? qrs_pkg::LIMIT_FLOOR
		: qrs_pkg::LIMIT_MAX - 6'($past(fold))))
		else $error("sense limit code wrong");

endmodule

// *** verification/qrs_flyback_model.sv ***
// Behavioural flyback stage: shunt ramp, auxiliary ringing, suppression level.
// Assumes the bench shapes each cycle through the i_ setting ports.
`timescale 1ns/10ps

module qrs_flyback_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_gate,
	input  wire logic [15:0] i_ramp,
	input  wire logic [15:0] i_period,
	input  wire logic [15:0] i_valleys,
	input  wire logic        i_supp,
	output logic             o_cs_above_fb,
	output logic             o_valley_below_zc,
	output logic             o_valley_above_suppress
);
	logic gate_q = 1'b0;
	int   age    = 0;

	// ----------------------------------------------------------------
	// Time since the last gate edge
	// ----------------------------------------------------------------
	always @(posedge i_core_clk) begin
		age    <= (i_gate !== gate_q) ? 0 : age + 1;
		gate_q <= i_gate;
	end

	// Ramp of zero never trips, so only the on-time limit, the current-limit input or a short-winding latch ends the pulse
	assign o_cs_above_fb = gate_q && i_ramp != 0 && age >= i_ramp;
	// Pin is clamped low while on: the detector reads below all on-time
	assign o_valley_below_zc = gate_q || (i_period != 0 && age >= i_period &&
		age / i_period <= i_valleys && age % i_period < i_period / 2);
	assign o_valley_above_suppress = i_supp;
endmodule

// *** verification/test_qrs_switch_timing.sv ***
// Self-checking bench for the quasi-resonant switch timing core.
// Assumes the flyback model closes the loop; pins change at falling edges.
`timescale 1ns/10ps

module test_qrs_switch_timing;
	localparam int EVAL = 2000;
	logic        i_core_clk = 1'b0;
	logic        i_rst_n    = 1'b0;
	logic        fb_low     = 1'b0;
	logic        fb_high    = 1'b0;
	logic        fb_rst     = 1'b0;
	logic        line_high  = 1'b0;
	logic        ovp        = 1'b0;
	logic        limit      = 1'b0;
	logic        short_w    = 1'b0;
	logic        supp       = 1'b1;
	logic [5:0]  excess     = 6'h00;
	logic [15:0] ramp       = 16'h0032;
	logic [15:0] period     = 16'h0014;
	logic [15:0] valleys    = 16'h0008;
	logic        gate, latched, zone, cs_fb, below_zc, above_supp;
	logic [2:0]  skip, count;
	logic [5:0]  limit_code;
	int          fails = 0, checks_done = 0, on_c, off_c;

	always #12.5 i_core_clk = ~i_core_clk;

	qrs_switch_timing #(.EVAL_CYC(EVAL), .FOLD_W(6)) dut (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_fb_above_zone_low(fb_low), .i_fb_above_zone_high(fb_high),
		.i_fb_above_reset(fb_rst), .i_line_high(line_high),
		.i_valley_below_zc(below_zc), .i_valley_above_ovp(ovp),
		.i_valley_above_suppress(above_supp), .i_cs_above_fb(cs_fb),
		.i_cs_above_limit(limit), .i_cs_above_short(short_w),
		.i_foldback_excess(excess), .o_gate_drive_output(gate),
		.o_latched_off(latched), .o_zone_set_high(zone), .o_valley_skip(skip),
		.o_valley_count(count), .o_cs_limit_code(limit_code));

	qrs_flyback_model model (
		.i_core_clk(i_core_clk), .i_gate(gate), .i_ramp(ramp), .i_period(period),
		.i_valleys(valleys), .i_supp(supp), .o_cs_above_fb(cs_fb),
		.o_valley_below_zc(below_zc), .o_valley_above_suppress(above_supp));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test;
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input bit ok, input string msg);
		checks_done++;
		if (!ok) begin
			fails++;
			$display("MISMATCH t=%0t %s", $time, msg);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask

	// Bounded wait; a stuck gate ends the run
	task automatic wait_gate(input logic v, output int n);
		n = 0;
		while (gate !== v && n < 4000) begin
			@(negedge i_core_clk);
			n++;
		end
		if (n >= 4000) begin
			fails++;
			$display("MISMATCH t=%0t gate stuck", $time);
			stop_test;
		end
	endtask

	// One whole switching cycle, counted from a fresh rising edge
	task automatic measure;
		int n;
		wait_gate(1'b0, n);
		wait_gate(1'b1, n);
		wait_gate(1'b0, on_c);
		wait_gate(1'b1, off_c);
	endtask

	task automatic wait_skip(input logic [2:0] v);
		int n;
		n = 0;
		while (skip !== v && n < 2 * EVAL + 40) begin
			@(negedge i_core_clk);
			n++;
		end
		chk(skip === v, "skip counter step");
		if (skip !== v) begin
			stop_test;
		end
	endtask

	task automatic do_reset;
		@(negedge i_core_clk);
		i_rst_n = 1'b0;
		cyc(3);
		i_rst_n = 1'b1;
	endtask

	// Valley count during a long off-time, then cleared by turn-on
	task automatic t_count(input logic [15:0] n, input logic [2:0] exp);
		int w;
		valleys = n;
		wait_gate(1'b1, w);
		wait_gate(1'b0, w);
		cyc(500);
		chk(count === exp, "valley count");
		wait_gate(1'b1, w);
		chk(count === 3'h0, "valley count clear");
		$display("test valley_count done");
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		logic [5:0] tab [4];
		logic [5:0] e;
		tab = '{6'h00, 6'h05, 6'h2F, 6'h30};
		do_reset;
		chk(skip === 3'h1, "reset skip");
		chk(count === 3'h0 && gate === 1'b0 && latched === 1'b0, "reset outputs");
		chk(limit_code === 6'h3F, "reset limit");
		for (int v = 2; v <= 7; v++) begin
			wait_skip(v[2:0]);
		end
		cyc(EVAL + 40);
		chk(skip === 3'h7, "skip saturate");
		fb_low = 1'b1;
		cyc(2 * EVAL);
		chk(skip === 3'h7, "skip hold");
		fb_high = 1'b1;
		fb_rst = 1'b1;
		cyc(8);
		chk(skip === 3'h1, "skip reload");
		{fb_low, fb_high, fb_rst} = 3'h0;
		wait_skip(3'h2);
		wait_skip(3'h3);
		fb_low = 1'b1;
		$display("test skip_up done");
		period = 16'h00C8;
		measure;
		chk(off_c >= 600 && off_c <= 612, "skip valleys");
		period = 16'h0014;
		$display("test valley_skip done");
		fb_high = 1'b1;
		wait_skip(3'h2);
		wait_skip(3'h1);
		cyc(2 * EVAL);
		chk(skip === 3'h1, "skip floor");
		fb_high = 1'b0;
		$display("test skip_down done");
		measure;
		chk(on_c >= 50 && on_c <= 60, "pwm off");
		chk(off_c >= 100 && off_c <= 110, "short ring");
		supp = 1'b0;
		measure;
		chk(off_c >= 1000 && off_c <= 1010, "long ring");
		$display("test ring done");
		t_count(16'h0003, 3'h3);
		t_count(16'h0009, 3'h7);
		supp = 1'b1;
		ramp = 16'h0000;
		measure;
		chk(on_c >= 1199 && on_c <= 1203, "max on");
		ramp = 16'h0001;
		measure;
		chk(on_c >= 10 && on_c <= 14, "blanking");
		ramp = 16'h0000;
		limit = 1'b1;
		measure;
		chk(on_c >= 10 && on_c <= 14, "current limit");
		limit = 1'b0;
		ramp = 16'h0032;
		valleys = 16'h0000;
		measure;
		chk(off_c >= 1995 && off_c <= 2005, "max off");
		valleys = 16'h0008;
		$display("test on_off_limits done");
		wait_gate(1'b0, on_c);
		ovp = 1'b1;
		cyc(20);
		ovp = 1'b0;
		cyc(300);
		chk(latched === 1'b0, "ovp spike");
		ovp = 1'b1;
		cyc(300);
		chk(latched === 1'b1 && gate === 1'b0, "ovp latch");
		ovp = 1'b0;
		do_reset;
		wait_gate(1'b1, on_c);
		short_w = 1'b1;
		cyc(4);
		short_w = 1'b0;
		cyc(300);
		chk(latched === 1'b0, "short spike");
		short_w = 1'b1;
		cyc(300);
		chk(latched === 1'b1 && gate === 1'b0, "short latch");
		short_w = 1'b0;
		do_reset;
		$display("test protect done");
		line_high = 1'b1;
		cyc(6);
		chk(zone === 1'b1, "zone high");
		line_high = 1'b0;
		cyc(6);
		chk(zone === 1'b0, "zone low");
		foreach (tab[i]) begin
			excess = tab[i];
			e = (6'h3F - tab[i] < 6'h10) ? 6'h10 : 6'h3F - tab[i];
			cyc(6);
			chk(limit_code === e, "foldback limit");
		end
		$display("test misc done");
		stop_test;
	end
endmodule
